// file: mgr_pkg.sv
// Constants shared by the monitor gain and ring delay register block.
// Assumes a single 125 MHz register clock and an 8-bit register port.
package mgr_pkg;

  // ************************************************************
  // Register map
  // ************************************************************
  localparam logic [7:0] ADDR_TX_GAIN   = 8'h15;
  localparam logic [7:0] ADDR_RING_CTL1 = 8'h16;
  localparam logic [7:0] RST_TX_GAIN    = 8'h00;
  localparam logic [7:0] RST_RING_CTL1  = 8'h00;
  localparam logic [7:0] RDATA_NONE     = 8'h00;

  // Field positions in the ring validation control register
  localparam int DLY_LO_MSB = 7;
  localparam int DLY_LO_LSB = 6;
  localparam int MAX_MSB    = 5;
  localparam int MAX_LSB    = 0;

  // ************************************************************
  // Gain scaling
  // ************************************************************
  localparam logic [7:0] GAIN_MUTE  = 8'h00;
  localparam int         GAIN_SHIFT = 6;    // Unity code is 64
  localparam int         SAMPLE_W   = 16;
  localparam int         PROD_W     = 25;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int CLK_PERIOD_NS    = 8;
  localparam int RING_STEP_MS     = 256;
  localparam int RING_STEP_CYCLES = RING_STEP_MS * 1000000 / CLK_PERIOD_NS;
  localparam int QUAL_TICK_US     = 2000;
  localparam int QUAL_TICK_CYCLES = QUAL_TICK_US * 1000 / CLK_PERIOD_NS;
  localparam int PRESC_W          = 25;
  localparam logic [PRESC_W-1:0] PRESC_ZERO = 25'h0000000;
  localparam logic [PRESC_W-1:0] PRESC_ONE  = 25'h0000001;
  localparam logic [2:0] DLY_ZERO  = 3'h0;
  localparam logic [2:0] DLY_ONE   = 3'h1;
  localparam logic [5:0] TMR_ZERO  = 6'h00;
  localparam logic [5:0] TMR_ONE   = 6'h01;

  // Ring indication states
  typedef enum logic [2:0] {
    RD_IDLE     = 3'b001,
    RD_WAIT     = 3'b010,
    RD_INDICATE = 3'b100
  } mgr_ring_e;

endpackage

// file: mgr_gain_scale.sv
// Linear gain stage for the transmit copy sent to the monitor output.
// Assumes samples arrive as signed words with a one-cycle valid strobe.
`timescale 1ns/100ps

module mgr_gain_scale (
  input  wire logic                                clk_in,
  input  wire logic                                rstn_in,
  input  wire logic signed [mgr_pkg::SAMPLE_W-1:0] sample_in,
  input  wire logic                                sample_valid_in,
  input  wire logic [7:0]                          gain_in,
  output logic signed [mgr_pkg::SAMPLE_W-1:0]      sample_out,
  output logic                                     sample_valid_out
);

  localparam logic signed [mgr_pkg::SAMPLE_W-1:0] MAX_S =
    {1'b0, {(mgr_pkg::SAMPLE_W-1){1'b1}}};
  localparam logic signed [mgr_pkg::SAMPLE_W-1:0] MIN_S =
    {1'b1, {(mgr_pkg::SAMPLE_W-1){1'b0}}};

  logic signed [mgr_pkg::PROD_W-1:0]   prod;
  logic signed [mgr_pkg::PROD_W-1:0]   scaled;
  logic signed [mgr_pkg::SAMPLE_W-1:0] out_d;
  logic signed [mgr_pkg::SAMPLE_W-1:0] out_q;
  logic                                vld_q;

  // ************************************************************
  // Scale by code/64 and saturate; gains above unity can clip
  // ************************************************************
  always_comb begin
    prod   = mgr_pkg::PROD_W'(sample_in) *
             $signed({1'b0, gain_in});                        // R2 R4
    scaled = prod >>> mgr_pkg::GAIN_SHIFT;                    // R2
    if (!sample_valid_in) begin
      out_d = out_q;                                          // Hold
    end else if (gain_in == mgr_pkg::GAIN_MUTE) begin
      out_d = '0;                                             // R3
    end else if (scaled > mgr_pkg::PROD_W'(MAX_S)) begin
      out_d = MAX_S;
    end else if (scaled < mgr_pkg::PROD_W'(MIN_S)) begin
      out_d = MIN_S;
    end else begin
      out_d = scaled[mgr_pkg::SAMPLE_W-1:0];
    end
  end

  // Output register, updated only with a new sample
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      out_q <= '0;
      vld_q <= 1'b0;
    end else begin
      out_q <= out_d;
      vld_q <= sample_valid_in;
    end
  end

  // Outputs straight from flip-flops
  assign sample_out       = out_q;
  assign sample_valid_out = vld_q;

endmodule // mgr_gain_scale

// file: mgr_regs.sv
// Monitor gain and ring validation control registers with the logic
// they steer. Assumes the register port and all event inputs are
// synchronous to CLK_IN.
// Both registers reset to zero, so the monitor copy starts muted.
//
// Functional notes
// R1 - Eight-bit read/write transmit monitor gain in bits 7 to 0.
// R2 - Monitor transmit copy scaled linearly by gain code over 64.
// R3 - Gain code zero mutes the transmit contribution completely.
// R4 - Code 64 unity, 255 +12 dB, 127 +6, 32 -6, 16 -12 dB.
// R5 - Delay low bits at 7:6, joined with a high bit held elsewhere.
// R6 - Valid ring reported only after the programmed delay expires.
// R7 - Delay code 0 gives 0 ms, 1 gives 256, 2 gives 512 ms.
// R8 - Timer loads start value per event; too high at next event invalidates.
// R9 - Each further delay code step adds another 256 ms.
`timescale 1ns/100ps

module mgr_regs #(
  parameter int unsigned RING_STEP_CYCLES = mgr_pkg::RING_STEP_CYCLES,
  parameter int unsigned QUAL_TICK_CYCLES = mgr_pkg::QUAL_TICK_CYCLES
) (
  input  wire logic                                CLK_IN,
  input  wire logic                                RSTN_IN,
  input  wire logic [7:0]                          REG_ADDR_IN,
  input  wire logic [7:0]                          REG_WDATA_IN,
  input  wire logic                                REG_WR_IN,
  input  wire logic                                REG_RD_IN,
  output logic [7:0]                               REG_RDATA_OUT,
  input  wire logic                                RING_DELAY_HIGH_IN,
  input  wire logic [5:0]                          RING_ASSERT_START_IN,
  input  wire logic                                TIP_RING_EVENT_IN,
  input  wire logic                                RING_VALID_IN,
  output logic                                     RING_INDICATE_OUT,
  output logic                                     RING_INVALID_OUT,
  input  wire logic signed [mgr_pkg::SAMPLE_W-1:0] TX_SAMPLE_IN,
  input  wire logic                                TX_SAMPLE_VALID_IN,
  output logic signed [mgr_pkg::SAMPLE_W-1:0]      MONITOR_TX_OUT,
  output logic                                     MONITOR_TX_VALID_OUT
);

  // ************************************************************
  // Prescaler end points
  // ************************************************************
  localparam logic [mgr_pkg::PRESC_W-1:0] STEP_LAST =
    mgr_pkg::PRESC_W'(RING_STEP_CYCLES - 1);
  localparam logic [mgr_pkg::PRESC_W-1:0] TICK_LAST =
    mgr_pkg::PRESC_W'(QUAL_TICK_CYCLES - 1);

  // ************************************************************
  // Register file
  // ************************************************************
  logic [7:0] tx_monitor_gain_q, tx_monitor_gain_d;
  logic [7:0] ring_ctl_q,        ring_ctl_d;
  logic [7:0] rdata_q,           rdata_d;
  logic [2:0] ring_delay_code;
  logic [5:0] ring_max_count;

  // Writes and registered read data; unmapped reads return zero
  always_comb begin
    tx_monitor_gain_d = tx_monitor_gain_q;
    ring_ctl_d        = ring_ctl_q;
    rdata_d           = rdata_q;
    if (REG_WR_IN && REG_ADDR_IN == mgr_pkg::ADDR_TX_GAIN) begin
      tx_monitor_gain_d = REG_WDATA_IN;                       // R1
    end
    if (REG_WR_IN && REG_ADDR_IN == mgr_pkg::ADDR_RING_CTL1) begin
      ring_ctl_d = REG_WDATA_IN;                              // R5
    end
    if (REG_RD_IN) begin
      case (REG_ADDR_IN)
        mgr_pkg::ADDR_TX_GAIN:   rdata_d = tx_monitor_gain_q; // R1
        mgr_pkg::ADDR_RING_CTL1: rdata_d = ring_ctl_q;
        default:                 rdata_d = mgr_pkg::RDATA_NONE;
      endcase
    end
  end

  // Register state; reset leaves the gain muted
  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      tx_monitor_gain_q <= mgr_pkg::RST_TX_GAIN;
      ring_ctl_q        <= mgr_pkg::RST_RING_CTL1;
      rdata_q           <= mgr_pkg::RDATA_NONE;
    end else begin
      tx_monitor_gain_q <= tx_monitor_gain_d;
      ring_ctl_q        <= ring_ctl_d;
      rdata_q           <= rdata_d;
    end
  end

  // High delay bit lives in the neighbouring register
  assign ring_delay_code = {RING_DELAY_HIGH_IN,
    ring_ctl_q[mgr_pkg::DLY_LO_MSB:mgr_pkg::DLY_LO_LSB]};     // R5
  assign ring_max_count  = ring_ctl_q[mgr_pkg::MAX_MSB:mgr_pkg::MAX_LSB];
  assign REG_RDATA_OUT   = rdata_q;

  // ************************************************************
  // Monitor transmit gain
  // ************************************************************
  mgr_gain_scale u_gain (
    .clk_in           (CLK_IN),
    .rstn_in          (RSTN_IN),
    .sample_in        (TX_SAMPLE_IN),
    .sample_valid_in  (TX_SAMPLE_VALID_IN),
    .gain_in          (tx_monitor_gain_q),
    .sample_out       (MONITOR_TX_OUT),
    .sample_valid_out (MONITOR_TX_VALID_OUT)
  );

  // ************************************************************
  // Ring indication delay
  // ************************************************************
  // Delay state, step prescaler and whole steps still to wait
  mgr_pkg::mgr_ring_e            rd_state_q, rd_state_d;
  logic [mgr_pkg::PRESC_W-1:0]   step_cnt_q, step_cnt_d;
  logic [2:0]                    steps_left_q, steps_left_d;

  // Counts whole 256 ms steps; dropping the valid level aborts at once
  always_comb begin
    rd_state_d   = rd_state_q;
    step_cnt_d   = step_cnt_q;
    steps_left_d = steps_left_q;
    case (rd_state_q)
      mgr_pkg::RD_IDLE: begin
        step_cnt_d   = mgr_pkg::PRESC_ZERO;
        steps_left_d = ring_delay_code;                       // R7 R9
        if (RING_VALID_IN) begin
          rd_state_d = (ring_delay_code == mgr_pkg::DLY_ZERO) ?
                       mgr_pkg::RD_INDICATE : mgr_pkg::RD_WAIT; // R7
        end
      end
      mgr_pkg::RD_WAIT: begin
        if (!RING_VALID_IN) begin
          rd_state_d = mgr_pkg::RD_IDLE;
        end else if (step_cnt_q == STEP_LAST) begin
          step_cnt_d   = mgr_pkg::PRESC_ZERO;
          steps_left_d = steps_left_q - mgr_pkg::DLY_ONE;     // R9
          if (steps_left_q == mgr_pkg::DLY_ONE) begin
            rd_state_d = mgr_pkg::RD_INDICATE;                // R6
          end
        end else begin
          step_cnt_d = step_cnt_q + mgr_pkg::PRESC_ONE;
        end
      end
      mgr_pkg::RD_INDICATE: begin
        if (!RING_VALID_IN) begin
          rd_state_d = mgr_pkg::RD_IDLE;
        end
      end
      default: begin
        rd_state_d = mgr_pkg::RD_IDLE;
      end
    endcase
  end

  // Delay state registers
  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      rd_state_q   <= mgr_pkg::RD_IDLE;
      step_cnt_q   <= mgr_pkg::PRESC_ZERO;
      steps_left_q <= mgr_pkg::DLY_ZERO;
    end else begin
      rd_state_q   <= rd_state_d;
      step_cnt_q   <= step_cnt_d;
      steps_left_q <= steps_left_d;
    end
  end

  // Decoded from the state register alone, so it cannot glitch
  assign RING_INDICATE_OUT = (rd_state_q == mgr_pkg::RD_INDICATE); // R6

  // ************************************************************
  // Ring qualification timer
  // ************************************************************
  // Tick prescaler, loaded timer, arm flag and invalid pulse
  logic [mgr_pkg::PRESC_W-1:0] tick_cnt_q, tick_cnt_d;
  logic [5:0]                  qual_tmr_q, qual_tmr_d;
  logic                        armed_q,    armed_d;
  logic                        invalid_q,  invalid_d;

  // First event only arms; comparison needs a previous load
  always_comb begin
    tick_cnt_d = tick_cnt_q;
    qual_tmr_d = qual_tmr_q;
    armed_d    = armed_q;
    invalid_d  = 1'b0;
    if (TIP_RING_EVENT_IN) begin
      invalid_d  = armed_q && (qual_tmr_q > ring_max_count);  // R8
      qual_tmr_d = RING_ASSERT_START_IN;                      // R8
      armed_d    = 1'b1;
      tick_cnt_d = mgr_pkg::PRESC_ZERO;
    end else if (tick_cnt_q == TICK_LAST) begin
      tick_cnt_d = mgr_pkg::PRESC_ZERO;
      if (qual_tmr_q != mgr_pkg::TMR_ZERO) begin
        qual_tmr_d = qual_tmr_q - mgr_pkg::TMR_ONE;           // R8
      end
    end else begin
      tick_cnt_d = tick_cnt_q + mgr_pkg::PRESC_ONE;
    end
  end

  // Qualifier registers
  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      tick_cnt_q <= mgr_pkg::PRESC_ZERO;
      qual_tmr_q <= mgr_pkg::TMR_ZERO;
      armed_q    <= 1'b0;
      invalid_q  <= 1'b0;
    end else begin
      tick_cnt_q <= tick_cnt_d;
      qual_tmr_q <= qual_tmr_d;
      armed_q    <= armed_d;
      invalid_q  <= invalid_d;
    end
  end

  // Registered one-cycle invalid pulse
  assign RING_INVALID_OUT = invalid_q;

endmodule // mgr_regs

// file: mgr_asserts.sv
// Checker for the monitor gain and ring control register block.
// Assumes it is bound to mgr_regs and sees only its ports.
`timescale 1ns/100ps

module mgr_asserts #(
  parameter int unsigned RING_STEP_CYCLES = 8,
  parameter int unsigned QUAL_TICK_CYCLES = 4
) (
  input wire logic                                CLK_IN,
  input wire logic                                RSTN_IN,
  input wire logic [7:0]                          REG_ADDR_IN,
  input wire logic [7:0]                          REG_WDATA_IN,
  input wire logic                                REG_WR_IN,
  input wire logic                                REG_RD_IN,
  input wire logic [7:0]                          REG_RDATA_OUT,
  input wire logic                                RING_DELAY_HIGH_IN,
  input wire logic                                TIP_RING_EVENT_IN,
  input wire logic                                RING_VALID_IN,
  input wire logic                                RING_INDICATE_OUT,
  input wire logic                                RING_INVALID_OUT,
  input wire logic                                TX_SAMPLE_VALID_IN,
  input wire logic signed [mgr_pkg::SAMPLE_W-1:0] MONITOR_TX_OUT,
  input wire logic                                MONITOR_TX_VALID_OUT
);
  // *****
  // Shadow of both registers
  // *****
  logic [7:0] gain_q, gain_d, ctl_q, ctl_d;

  // Next shadow values, mirroring host writes
  always_comb begin
    gain_d = gain_q;
    ctl_d  = ctl_q;
    if (REG_WR_IN && REG_ADDR_IN == 8'h15) gain_d = REG_WDATA_IN;
    if (REG_WR_IN && REG_ADDR_IN == 8'h16) ctl_d = REG_WDATA_IN;
  end

  // Shadow registers
  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) {gain_q, ctl_q} <= 16'h0000;
    else {gain_q, ctl_q} <= {gain_d, ctl_d};
  end

  // Length of the current valid run and the delay code at its start
  logic [31:0] run_q, run_d, dly_len;
  logic [2:0]  code_q, code_d;

  // Code is taken on the first valid cycle, as the idle state does
  always_comb begin
    run_d  = RING_VALID_IN ? run_q + 32'h1 : 32'h0;
    code_d = code_q;
    if (RING_VALID_IN && run_q == 32'h0) begin
      code_d = {RING_DELAY_HIGH_IN, ctl_q[7:6]};
    end
    dly_len = 32'(code_q) * RING_STEP_CYCLES + 32'h1;
  end

  // Run counter and captured code
  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      run_q  <= 32'h0;
      code_q <= 3'h0;
    end else begin
      run_q  <= run_d;
      code_q <= code_d;
    end
  end

  // *****
  // Properties
  // *****
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RSTN_IN);

  AST_TX_VALID: assert property (
    TX_SAMPLE_VALID_IN |=> MONITOR_TX_VALID_OUT)
    else $error("Monitor valid missing");
  AST_MUTE: assert property (
    TX_SAMPLE_VALID_IN && gain_q == 8'h00 |=> MONITOR_TX_OUT == 16'sh0)
    else $error("Muted path not zero");
  AST_RD_GAIN: assert property (
    REG_RD_IN && REG_ADDR_IN == 8'h15 |=> REG_RDATA_OUT == $past(gain_q))
    else $error("Gain readback wrong");
  AST_RD_CTL: assert property (
    REG_RD_IN && REG_ADDR_IN == 8'h16 |=> REG_RDATA_OUT == $past(ctl_q))
    else $error("Ring control readback wrong");
  AST_RD_NONE: assert property (
    REG_RD_IN && REG_ADDR_IN != 8'h15 && REG_ADDR_IN != 8'h16
    |=> REG_RDATA_OUT == 8'h00) else $error("Unmapped read not zero");
  AST_DLY_ZERO: assert property (
    $rose(RING_VALID_IN) && ctl_q[7:6] == 2'b00 && !RING_DELAY_HIGH_IN
    |=> RING_INDICATE_OUT) else $error("Zero delay indicate late");
  AST_IND_DROP: assert property (
    !RING_VALID_IN |=> !RING_INDICATE_OUT)
    else $error("Indicate without valid ring");
  AST_INV_CAUSE: assert property (
    RING_INVALID_OUT |-> $past(TIP_RING_EVENT_IN))
    else $error("Invalid pulse without event");
  AST_DLY_LEN: assert property (
    $rose(RING_INDICATE_OUT) |-> run_q == dly_len)
    else $error("Ring indicate delay length wrong");
endmodule // mgr_asserts

bind mgr_regs mgr_asserts #(
  .RING_STEP_CYCLES(RING_STEP_CYCLES),
  .QUAL_TICK_CYCLES(QUAL_TICK_CYCLES)
) u_asserts (.CLK_IN, .RSTN_IN, .REG_ADDR_IN, .REG_WDATA_IN, .REG_WR_IN,
  .REG_RD_IN, .REG_RDATA_OUT, .RING_DELAY_HIGH_IN, .TIP_RING_EVENT_IN,
  .RING_VALID_IN, .RING_INDICATE_OUT, .RING_INVALID_OUT,
  .TX_SAMPLE_VALID_IN, .MONITOR_TX_OUT, .MONITOR_TX_VALID_OUT);

// file: tb_top.sv
// Self-checking bench for the gain and ring control register block.
// Assumes short delay step and tick counts set by parameter.
`timescale 1ns/100ps

module tb_top;
  localparam int STEP = 8;
  logic clk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0, dhi = 1'b0;
  logic ev = 1'b0, rvalid = 1'b0, txv = 1'b0, ind, inv, monv;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
  logic [5:0] start = 6'h00;
  logic signed [15:0] txs = 16'sh0, mon;
  int n_errors = 0, comparisons = 0, cyc = 0;

  mgr_regs #(.RING_STEP_CYCLES(STEP), .QUAL_TICK_CYCLES(4)) uut (
    .CLK_IN(clk), .RSTN_IN(rstn), .REG_ADDR_IN(addr),
    .REG_WDATA_IN(wdata), .REG_WR_IN(wr), .REG_RD_IN(rd),
    .REG_RDATA_OUT(rdata), .RING_DELAY_HIGH_IN(dhi),
    .RING_ASSERT_START_IN(start), .TIP_RING_EVENT_IN(ev),
    .RING_VALID_IN(rvalid), .RING_INDICATE_OUT(ind),
    .RING_INVALID_OUT(inv), .TX_SAMPLE_IN(txs),
    .TX_SAMPLE_VALID_IN(txv), .MONITOR_TX_OUT(mon),
    .MONITOR_TX_VALID_OUT(monv));

  // *****
  // Clock, hang guard, shared tasks
  // *****
  always #4 clk = ~clk;

  // Run needs well under 2000 cycles; 4000 means a hang
  always @(posedge clk) begin
    cyc++;
    if (cyc == 4000) begin
      n_errors++;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wreg(logic [7:0] a, logic [7:0] d);
    @(posedge clk) begin addr <= a; wdata <= d; wr <= 1'b1; end
    @(posedge clk) wr <= 1'b0;
  endtask

  task automatic rreg(logic [7:0] a, logic [7:0] e);
    @(posedge clk) begin addr <= a; rd <= 1'b1; end
    @(posedge clk) rd <= 1'b0;
    #1 chk("rdata", {8'h00, e}, {8'h00, rdata});
  endtask

  // *****
  // Scenarios
  // *****
  // First event only arms; gaps let the 4-cycle tick count down
  task automatic t_qual();
    logic [5:0] st [6] = '{6'h0a, 6'h03, 6'h03, 6'h08, 6'h08, 6'h00};
    logic       ex [6] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
    int         gp [6] = '{0, 0, 0, 0, 4, 12};
    wreg(8'h16, 8'h05);
    foreach (st[i]) begin
      repeat (gp[i]) @(posedge clk);
      @(posedge clk) begin start <= st[i]; ev <= 1'b1; end
      @(posedge clk) ev <= 1'b0;
      #1 chk("invalid", {15'h0, ex[i]}, {15'h0, inv});
    end
  endtask

  task automatic t_regs();
    rreg(8'h15, 8'h00);
    rreg(8'h16, 8'h00);
    wreg(8'h15, 8'ha5);
    wreg(8'h16, 8'h5a);
    rreg(8'h15, 8'ha5);
    rreg(8'h16, 8'h5a);
    rreg(8'h17, 8'h00);
  endtask

  // Negative sample checks the floor of the shift
  task automatic t_gain();
    logic [7:0] g [6] = '{8'h00, 8'h10, 8'h20, 8'h40, 8'h7f, 8'hff};
    foreach (g[i]) begin
      wreg(8'h15, g[i]);
      @(posedge clk) begin txs <= -16'sh03e8; txv <= 1'b1; end
      @(posedge clk) txv <= 1'b0;
      #1 chk("mon", 16'((-1000 * int'(g[i])) >>> 6), mon);
      chk("monv", 16'h1, {15'h0, monv});
    end
  endtask

  task automatic t_delay(logic [2:0] c);
    int n;
    wreg(8'h16, {c[1:0], 6'h3f});
    @(posedge clk) begin dhi <= c[2]; rvalid <= 1'b1; end
    n = 0;
    do begin
      @(posedge clk);
      n++;
      #1;
    end while (!ind && n < 100);
    chk("delay", 16'(1 + c * STEP), 16'(n));
    @(posedge clk) rvalid <= 1'b0;
    repeat (2) @(posedge clk);
    #1 chk("drop", 16'h0, {15'h0, ind});
  endtask

  // Valid ring lost while waiting must never be indicated
  task automatic t_abort();
    wreg(8'h16, 8'h40);
    @(posedge clk) begin dhi <= 1'b0; rvalid <= 1'b1; end
    repeat (3) @(posedge clk);
    rvalid <= 1'b0;
    repeat (12) begin
      @(posedge clk);
      #1 chk("abort", 16'h0, {15'h0, ind});
    end
  endtask

  initial begin
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    t_regs();
    t_qual();
    t_gain();
    for (int c = 0; c < 8; c++) t_delay(3'(c));
    t_abort();
    end_sim();
  end
endmodule // tb_top
